/* File: include/flame_cfg_regs.svh */
// Register offsets, field codes, defaults and timing of the flame configuration block
`ifndef FLAME_CFG_REGS_SVH
`define FLAME_CFG_REGS_SVH
`define A_PENDING 8'h00
`define A_TARGET 8'h04
`define A_STORE 8'h08
`define A_LOCK 8'h0C
`define A_ALTSEL 8'h10
`define A_STATUS 8'h14
`define A_SERIAL 8'h18
`define A_READBACK 8'h1C
`define F_HEAD 4'h0
`define F_MODE 4'h1
`define F_RESP_TIME 4'h2
`define F_DELAY 4'h3
`define F_GAIN 4'h4
`define F_ALARM 4'h5
`define F_ON 4'h6
`define F_OFF 4'h7
`define F_ADDR 4'h8
`define F_BAUD 4'h9
`define F_PARITY 4'hA
`define F_RANGE 4'hB
`define F_CHDEF 4'hC
`define F_GLDEF 4'hD
`define F_PWR 4'hE
`define DEF_MODE 2'h0
`define DEF_RESP_TIME 2'h3
`define DEF_DELAY 8'h01
`define DEF_GAIN 7'h0A
`define DEF_ALARM 16'h0000
`define DEF_ON 16'h0320
`define DEF_OFF 16'h0258
`define DEF_ADDR 8'h00
`define DEF_BAUD 2'h0
`define DEF_PARITY 2'h0
`define DEF_RANGE 1'h1
`define GAIN_MAX 16'h0064
`define RESP_TIME_MAX 16'h0003
`define TEMP_HOT_C 8'h46
`define CLK_HZ 32'h02FA_F080
`define HOLD_S 32'h0000_0002
`define PWR_OFF_MS 32'h0000_01F4
`define MS_PER_S 32'h0000_03E8
`endif

/* File: include/flame_cfg_pkg.sv */
// Types shared by the flame configuration block
`default_nettype none
package flame_cfg_pkg;
   typedef struct packed {
      logic [1:0] head;
      logic [1:0] mode;
      logic [1:0] flame_failure_response_time;
      logic [7:0] delay_on;
      logic [6:0] gain;
      logic [15:0] alarm_sp;
      logic [15:0] on_sp;
      logic [15:0] off_sp;
   } chan_cfg_t;
   typedef struct packed {
      logic alt;
      logic [1:0] ch;
      logic [3:0] field;
   } target_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [1:0] baud;
      logic [1:0] parity;
      logic range_4_20;
   } serial_cfg_t;
   typedef enum logic [0:0] {CMD_IDLE, CMD_ARMED} cmd_state_t;
endpackage
`default_nettype wire

/* File: src/flame_relay_timer.sv */
// Consecutive-second on/off timing of one flame relay
`timescale 1ns/100ps
`default_nettype none
module flame_relay_timer (
   input wire logic clk,         // System clock
   input wire logic rst_b,       // Async reset, active low
   input wire logic tick,        // One-second time base pulse
   input wire logic [15:0] count, // Flame count
   input wire logic [15:0] on_sp, // Flame on set point
   input wire logic [15:0] off_sp, // Flame off set point
   input wire logic [7:0] delay_on, // Relay-on delay, seconds
   input wire logic [1:0] flame_failure_response_time, // Failure response time, seconds
   output logic relay_r          // Flame relay energized
);
   logic [7:0] on_cnt_r, on_cnt_nxt;
   logic [1:0] off_cnt_r, off_cnt_nxt;
   logic relay_nxt;
   wire logic above = count > on_sp;
   wire logic below = count < off_sp;
   wire logic [7:0] on_inc = on_cnt_r + 8'h01;
   wire logic [1:0] off_inc = off_cnt_r + 2'h1;

   always_comb begin
      on_cnt_nxt = on_cnt_r;
      off_cnt_nxt = off_cnt_r;
      relay_nxt = relay_r;
      if (tick) begin
         if (!relay_r) begin
            off_cnt_nxt = 2'h0;
            if (!above) begin
               on_cnt_nxt = 8'h00;
            end else if (on_inc >= delay_on) begin
               relay_nxt = 1'b1;
               on_cnt_nxt = 8'h00;
            end else begin
               on_cnt_nxt = on_inc;
            end
         end else begin
            on_cnt_nxt = 8'h00;
            if (!below) begin
               off_cnt_nxt = 2'h0;
            end else if (off_inc >= flame_failure_response_time) begin
               relay_nxt = 1'b0;
               off_cnt_nxt = 2'h0;
            end else begin
               off_cnt_nxt = off_inc;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         on_cnt_r <= 8'h00;
         off_cnt_r <= 2'h0;
         relay_r <= 1'b0;
      end else begin
         on_cnt_r <= on_cnt_nxt;
         off_cnt_r <= off_cnt_nxt;
         relay_r <= relay_nxt;
      end
   end

   property p_on_cause;
      @(posedge clk) disable iff (!rst_b) $rose(relay_r) |-> $past(tick) && $past(above);
   endproperty
   a_on_cause: assert property (p_on_cause) else $error("relay rose without tick above on");
   property p_off_cause;
      @(posedge clk) disable iff (!rst_b) $fell(relay_r) |-> $past(tick) && $past(below);
   endproperty
   a_off_cause: assert property (p_off_cause) else $error("relay fell without tick below off");
   property p_off_len;
      @(posedge clk) disable iff (!rst_b)
         $fell(relay_r) |-> $past(off_inc) >= $past(flame_failure_response_time);
   endproperty
   a_off_len: assert property (p_off_len) else $error("relay fell before response time");
   property p_restart;
      @(posedge clk) disable iff (!rst_b) tick && !relay_r && !above |=> on_cnt_r == 8'h00;
   endproperty
   a_restart: assert property (p_restart) else $error("on counter not restarted");
endmodule
`default_nettype wire

/* File: src/flame_cfg_ctrl.sv */
// Configuration store, command sequencing and relay decisions of the three-channel flame monitor
`timescale 1ns/100ps
`default_nettype none
`include "flame_cfg_regs.svh"
module flame_cfg_ctrl
   import flame_cfg_pkg::*;
#(
   parameter logic [26:0] HOLD_CYCLES = 27'(`HOLD_S * `CLK_HZ),
   parameter logic [24:0] PWR_OFF_CYCLES = 25'(`CLK_HZ / `MS_PER_S * `PWR_OFF_MS),
   parameter logic [15:0] LOCK_KEY = 16'h5A5A // Arbitrary value
) (
   input wire logic clk,                    // System clock, 50 MHz
   input wire logic rst_b,                  // Async reset, active low
   input wire logic [7:0] addr,             // Register byte address
   input wire logic [31:0] wdata,           // Register write data
   input wire logic wr,                     // Write strobe
   input wire logic rd,                     // Read strobe
   output logic [31:0] rdata_r,             // Read data, cycle after rd
   input wire logic tick_1s,                // One-second time base pulse
   input wire logic [4:0] button,           // Menu buttons, high while pressed
   input wire logic [2:0][15:0] flame_count, // Flame count per channel
   input wire logic [1:0][7:0] head_temp,   // Temperature of heads 1 and 2, deg C
   input wire logic [1:0] head_has_temp,    // Head 1/2 has a temperature sensor
   input wire logic [2:0] alt_select,       // Alternate select terminals
   input wire logic frame_valid,            // Serial frame address valid
   input wire logic [7:0] frame_addr,       // Serial frame destination
   output logic [2:0] flame_relay,          // Flame relays
   output logic [2:0] alarm_relay_r,        // Alarm relays
   output logic [2:0] active_alt_r,         // Alternate set drives the channel
   output logic [2:0][15:0] analog_r,       // Analog output level per channel
   output var flame_cfg_pkg::serial_cfg_t ser_r, // Stored serial and range settings
   output logic [4:0] menu_open_r,          // Menu open pulse per button
   output logic [7:0] temp_show_r,          // Temperature of the viewed head
   output logic answer_r,                   // Frame addressed to this node
   output logic head_power_off_r,           // Head supply cut
   output logic proc_restart_r              // Processor restart pulse
);
   import flame_cfg_pkg::*;

   logic [31:0] pend_r;
   target_t tgt_r;
   chan_cfg_t cfg_r [2][3];
   chan_cfg_t cfg_sel, cfg_wr;
   logic lock_r, in_use_r, refused_r, conflict, val_ok;
   logic [2:0] ser_alt_r;
   cmd_state_t cmd_st_r;
   logic [3:0] arm_field_r;
   logic [24:0] pwr_cnt_r;
   logic [15:0] rb;
   logic [31:0] rd_mux;
   wire chan_cfg_t act_cfg [3];
   wire logic [2:0] alarm_nxt, act_nxt;
   wire logic [2:0][15:0] analog_nxt;
   wire logic [4:0] menu_nxt;

   wire logic [15:0] pv = pend_r[15:0];
   wire logic [1:0] ch_i = (tgt_r.ch == 2'h3) ? 2'h2 : tgt_r.ch;
   wire logic store_wr = wr && addr == `A_STORE;
   wire logic is_cmd = tgt_r.field >= `F_CHDEF;
   wire logic store_ok = store_wr && !lock_r && !is_cmd && val_ok;
   wire logic exec = store_wr && !lock_r && cmd_st_r == CMD_ARMED
                     && tgt_r.field == arm_field_r;
   wire logic do_chdef = exec && tgt_r.field == `F_CHDEF;
   wire logic do_gldef = exec && tgt_r.field == `F_GLDEF;
   wire logic do_pwr = exec && tgt_r.field == `F_PWR;
   wire logic head_refused = store_wr && !lock_r && tgt_r.field == `F_HEAD && conflict;

   function automatic chan_cfg_t def_cfg(input logic [1:0] c);
      chan_cfg_t d;
      d.head = c + 2'h1;
      d.mode = `DEF_MODE;
      d.flame_failure_response_time = `DEF_RESP_TIME;
      d.delay_on = `DEF_DELAY;
      d.gain = `DEF_GAIN;
      d.alarm_sp = `DEF_ALARM;
      d.on_sp = `DEF_ON;
      d.off_sp = `DEF_OFF;
      return d;
   endfunction

   assign cfg_sel = cfg_r[tgt_r.alt][ch_i];

   // Same sensor may serve both sets of one channel, or several channels of one set
   always_comb begin
      conflict = 1'b0;
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 3; c++) begin
            if (pv[1:0] != 2'h0 && cfg_r[s][c].head == pv[1:0] && 2'(c) != ch_i
                && 1'(s) != tgt_r.alt) begin
               conflict = 1'b1;
            end
         end
      end
   end

   always_comb begin
      case (tgt_r.field)
         `F_HEAD: val_ok = pv <= 16'h0003 && !conflict && tgt_r.ch != 2'h3;
         `F_MODE: val_ok = pv <= 16'h0002 && tgt_r.ch != 2'h3;
         `F_RESP_TIME: val_ok = pv != 16'h0000 && pv <= `RESP_TIME_MAX && tgt_r.ch != 2'h3;
         `F_DELAY: val_ok = pv <= 16'h00FF && tgt_r.ch != 2'h3;
         `F_GAIN: val_ok = pv <= `GAIN_MAX && tgt_r.ch != 2'h3;
         `F_ALARM, `F_ON, `F_OFF: val_ok = tgt_r.ch != 2'h3;
         `F_ADDR: val_ok = pv <= 16'h00FF;
         `F_BAUD: val_ok = pv <= 16'h0003;
         `F_PARITY: val_ok = pv <= 16'h0002;
         `F_RANGE: val_ok = pv <= 16'h0001;
         default: val_ok = 1'b0;
      endcase
   end

   always_comb begin
      cfg_wr = cfg_sel;
      rb = 16'h0000;
      case (tgt_r.field)
         `F_HEAD: begin
            cfg_wr.head = pv[1:0];
            rb = {14'h0000, cfg_sel.head};
         end
         `F_MODE: begin
            cfg_wr.mode = pv[1:0];
            rb = {14'h0000, cfg_sel.mode};
         end
         `F_RESP_TIME: begin
            cfg_wr.flame_failure_response_time = pv[1:0];
            rb = {14'h0000, cfg_sel.flame_failure_response_time};
         end
         `F_DELAY: begin
            cfg_wr.delay_on = pv[7:0];
            rb = {8'h00, cfg_sel.delay_on};
         end
         `F_GAIN: begin
            cfg_wr.gain = pv[6:0];
            rb = {9'h000, cfg_sel.gain};
         end
         `F_ALARM: begin
            cfg_wr.alarm_sp = pv;
            rb = cfg_sel.alarm_sp;
         end
         `F_ON: begin
            cfg_wr.on_sp = pv;
            rb = cfg_sel.on_sp;
         end
         `F_OFF: begin
            cfg_wr.off_sp = pv;
            rb = cfg_sel.off_sp;
         end
         `F_ADDR: rb = {8'h00, ser_r.addr};
         `F_BAUD: rb = {14'h0000, ser_r.baud};
         `F_PARITY: rb = {14'h0000, ser_r.parity};
         `F_RANGE: rb = {15'h0000, ser_r.range_4_20};
         default: rb = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 3; c++) begin
               cfg_r[s][c] <= def_cfg(2'(c));
            end
         end
      end else if (do_gldef) begin
         for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 3; c++) begin
               cfg_r[s][c] <= def_cfg(2'(c));
            end
         end
      end else if (do_chdef) begin
         cfg_r[tgt_r.alt][ch_i] <= def_cfg(ch_i);
         cfg_r[tgt_r.alt][ch_i].head <= cfg_sel.head;
      end else if (store_ok && tgt_r.field <= `F_OFF) begin
         cfg_r[tgt_r.alt][ch_i] <= cfg_wr;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ser_r <= '{`DEF_ADDR, `DEF_BAUD, `DEF_PARITY, `DEF_RANGE};
      end else if (do_gldef) begin
         ser_r <= '{`DEF_ADDR, `DEF_BAUD, `DEF_PARITY, `DEF_RANGE};
      end else if (store_ok) begin
         case (tgt_r.field)
            `F_ADDR: ser_r.addr <= pv[7:0];
            `F_BAUD: ser_r.baud <= pv[1:0];
            `F_PARITY: ser_r.parity <= pv[1:0];
            `F_RANGE: ser_r.range_4_20 <= pv[0];
            default: ser_r <= ser_r;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_st_r <= CMD_IDLE;
         arm_field_r <= 4'h0;
      end else if (store_wr) begin
         case (cmd_st_r)
            CMD_IDLE: begin
               if (is_cmd && !lock_r && pv == 16'h0001) begin
                  cmd_st_r <= CMD_ARMED;
                  arm_field_r <= tgt_r.field;
               end
            end
            default: cmd_st_r <= CMD_IDLE;
         endcase
      end
   end

   // Pending value and view target are free even when locked; only stores are barred
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= 32'h0000_0000;
         tgt_r <= '0;
         lock_r <= 1'b0;
         ser_alt_r <= 3'h0;
      end else begin
         if (wr && addr == `A_PENDING) pend_r <= wdata;
         if (wr && addr == `A_TARGET) tgt_r <= target_t'(wdata[6:0]);
         if (wr && addr == `A_LOCK && wdata[15:0] == LOCK_KEY) lock_r <= !lock_r;
         if (do_gldef) begin
            ser_alt_r <= 3'h0;
         end else if (wr && addr == `A_ALTSEL) begin
            ser_alt_r <= wdata[2:0];
         end
      end
   end

   // Warning stands until a head store succeeds once the other user is moved
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_use_r <= 1'b0;
         refused_r <= 1'b0;
      end else if (store_wr) begin
         if (head_refused) in_use_r <= 1'b1;
         else if (store_ok && tgt_r.field == `F_HEAD) in_use_r <= 1'b0;
         refused_r <= !(store_ok || exec || cmd_st_r == CMD_IDLE && is_cmd && !lock_r);
      end
   end

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : gen_ch
         wire logic alt_w = alt_select[i] | ser_alt_r[i];
         wire logic adj = tgt_r.field == `F_GAIN && tgt_r.ch == 2'(i) && tgt_r.alt == alt_w;
         wire logic [6:0] g = adj ? pend_r[6:0] : act_cfg[i].gain;
         wire logic [22:0] prod = 23'(flame_count[i]) * 23'(g);
         wire logic both_zero = cfg_r[0][i].alarm_sp == 16'h0000
                                && cfg_r[1][i].alarm_sp == 16'h0000;
         logic hot;
         if (i < 2) begin : gen_hot
            assign hot = head_has_temp[i] && head_temp[i] >= `TEMP_HOT_C;
         end else begin : gen_cold
            assign hot = 1'b0;
         end
         assign act_cfg[i] = alt_w ? cfg_r[1][i] : cfg_r[0][i];
         assign act_nxt[i] = alt_w;
         assign analog_nxt[i] = (|prod[22:16]) ? 16'hFFFF : prod[15:0];
         assign alarm_nxt[i] = (act_cfg[i].alarm_sp != 16'h0000)
                               ? flame_count[i] >= act_cfg[i].alarm_sp
                               : both_zero && hot;
         flame_relay_timer u_timer (
            .clk(clk),
            .rst_b(rst_b),
            .tick(tick_1s),
            .count(flame_count[i]),
            .on_sp(act_cfg[i].on_sp),
            .off_sp(act_cfg[i].off_sp),
            .delay_on(act_cfg[i].delay_on),
            .flame_failure_response_time(act_cfg[i].flame_failure_response_time),
            .relay_r(flame_relay[i])
         );
      end
      for (i = 0; i < 5; i++) begin : gen_btn
         logic [26:0] cnt_r;
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) cnt_r <= 27'h000_0000;
            else if (!button[i]) cnt_r <= 27'h000_0000;
            else if (cnt_r != HOLD_CYCLES) cnt_r <= cnt_r + 27'h000_0001;
         end
         assign menu_nxt[i] = button[i] && cnt_r == HOLD_CYCLES - 27'h000_0001;
      end
   endgenerate

   always_comb begin
      if (addr == `A_PENDING) rd_mux = pend_r;
      else if (addr == `A_TARGET) rd_mux = {25'h000_0000, tgt_r};
      else if (addr == `A_ALTSEL) rd_mux = {29'h0000_0000, ser_alt_r};
      else if (addr == `A_STATUS) rd_mux = {18'h0_0000, head_power_off_r, active_alt_r,
         alarm_relay_r, flame_relay, refused_r, in_use_r, cmd_st_r == CMD_ARMED, lock_r};
      else if (addr == `A_SERIAL) rd_mux = {19'h0_0000, ser_r};
      else if (addr == `A_READBACK) rd_mux = {16'h0000, rb};
      else rd_mux = 32'h0000_0000;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_cnt_r <= 25'h000_0000;
      end else if (do_pwr) begin
         pwr_cnt_r <= PWR_OFF_CYCLES;
      end else if (pwr_cnt_r != 25'h000_0000) begin
         pwr_cnt_r <= pwr_cnt_r - 25'h000_0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 32'h0000_0000;
         alarm_relay_r <= 3'h0;
         active_alt_r <= 3'h0;
         analog_r <= '0;
         menu_open_r <= 5'h00;
         temp_show_r <= 8'h00;
         answer_r <= 1'b0;
         head_power_off_r <= 1'b0;
         proc_restart_r <= 1'b0;
      end else begin
         rdata_r <= rd ? rd_mux : 32'h0000_0000;
         alarm_relay_r <= alarm_nxt;
         active_alt_r <= act_nxt;
         analog_r <= analog_nxt;
         menu_open_r <= menu_nxt;
         temp_show_r <= (!tgt_r.ch[1] && head_has_temp[tgt_r.ch[0]])
                        ? head_temp[tgt_r.ch[0]] : 8'h00;
         answer_r <= frame_valid && frame_addr == ser_r.addr && frame_addr != 8'h00;
         head_power_off_r <= do_pwr || pwr_cnt_r > 25'h000_0001;
         proc_restart_r <= pwr_cnt_r == 25'h000_0001;
      end
   end

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
         menu_open_r[0] |-> $past(button[0]) && $past(button[0], 2);
   endproperty
   a_hold: assert property (p_hold) else $error("menu opened without held button");
   property p_alarm_zero;
      @(posedge clk) disable iff (!rst_b) act_cfg[2].alarm_sp == 16'h0000 |=> !alarm_relay_r[2];
   endproperty
   a_alarm_zero: assert property (p_alarm_zero) else $error("alarm on with zero set point");
   property p_hot;
      @(posedge clk) disable iff (!rst_b)
         gen_ch[0].both_zero && head_has_temp[0] && head_temp[0] >= `TEMP_HOT_C
         |=> alarm_relay_r[0];
   endproperty
   a_hot: assert property (p_hot) else $error("hot head alarm missing");
   property p_no_bcast;
      @(posedge clk) disable iff (!rst_b) answer_r |-> $past(frame_addr) != 8'h00;
   endproperty
   a_no_bcast: assert property (p_no_bcast) else $error("answered broadcast address");
   property p_lock;
      @(posedge clk) disable iff (!rst_b)
         lock_r && store_wr |=> $stable(ser_r) && !head_power_off_r && cmd_st_r == CMD_IDLE;
   endproperty
   a_lock: assert property (p_lock) else $error("change taken while locked");
   property p_confirm;
      @(posedge clk) disable iff (!rst_b)
         $rose(head_power_off_r) |-> $past(cmd_st_r) == CMD_ARMED && $past(store_wr);
   endproperty
   a_confirm: assert property (p_confirm) else $error("power reset without confirm");
   property p_pwr;
      @(posedge clk) disable iff (!rst_b) do_pwr |=> head_power_off_r ##1 head_power_off_r;
   endproperty
   a_pwr: assert property (p_pwr) else $error("power cut missing");
   property p_gain;
      @(posedge clk) disable iff (!rst_b) cfg_r[0][0].gain <= 7'h64 && cfg_r[1][0].gain <= 7'h64;
   endproperty
   a_gain: assert property (p_gain) else $error("gain above range");
   property p_pending;
      @(posedge clk) disable iff (!rst_b) !store_wr |=> $stable(ser_r);
   endproperty
   a_pending: assert property (p_pending) else $error("setting changed without store");
   property p_active;
      @(posedge clk) disable iff (!rst_b) active_alt_r == $past(alt_select | ser_alt_r);
   endproperty
   a_active: assert property (p_active) else $error("active set wrong");
endmodule
`default_nettype wire

/* File: test/panel_head_model.sv */
// Front panel and viewing head model
`timescale 1ns/100ps
`default_nettype none
module panel_head_model (
   input wire logic [4:0] press,      // Buttons the operator holds
   input wire logic [7:0] temp1,      // Head 1 temperature
   output logic [4:0] button,         // Panel buttons
   output logic [1:0][7:0] head_temp, // Head temperatures
   output logic [1:0] has_temp        // Sensor fitted
);
   assign button = press; // Hold length set by caller
   // Head 2 has no sensor; its line carries junk the block must ignore
   assign head_temp = {~temp1, temp1};
   assign has_temp = 2'b01;
endmodule
`default_nettype wire

/* File: test/flame_relay_config_control_test.sv */
// Self-checking bench of the flame configuration block
`timescale 1ns/100ps
`default_nettype none
`include "flame_cfg_regs.svh"
module flame_relay_config_control_test;
   import flame_cfg_pkg::*;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, tick = 0, fv = 0;
   logic [7:0] addr = 0, faddr = 0, temp1 = 0;
   logic [31:0] wdata = 0, seed = 32'h0000_0839;
   logic [4:0] press = 0, button;
   logic [2:0][15:0] cnt = 0;
   logic [1:0][7:0] htemp;
   logic [1:0] has_t;
   logic [2:0] relay, alarm;
   logic [31:0] rdata;
   logic [4:0] menu;
   logic ans;
   logic [2:0] alt = 0, act;
   logic [2:0][15:0] ana;
   logic [7:0] tshow;
   logic poff, prst;
   int num_errors = 0, samples_checked = 0, n;
   serial_cfg_t ser;
   initial forever #10 clk = ~clk;
   panel_head_model i_ph (.press(press), .temp1(temp1), .button(button), .head_temp(htemp),
      .has_temp(has_t));
   flame_cfg_ctrl #(.HOLD_CYCLES(27'h000_0008), .PWR_OFF_CYCLES(25'h000_0005)) i_dut (
      .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata),
      .tick_1s(tick), .button(button), .flame_count(cnt), .head_temp(htemp),
      .head_has_temp(has_t), .alt_select(alt), .frame_valid(fv), .frame_addr(faddr),
      .flame_relay(relay), .alarm_relay_r(alarm), .active_alt_r(act), .analog_r(ana),
      .ser_r(ser), .menu_open_r(menu), .temp_show_r(tshow), .answer_r(ans),
      .head_power_off_r(poff), .proc_restart_r(prst));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic hot(input logic [7:0] t);
      return t >= `TEMP_HOT_C;
   endfunction
   function automatic logic [15:0] scale(input logic [15:0] c, input logic [6:0] g);
      logic [31:0] p;
      p = 32'(c) * 32'(g);
      return (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk) wr <= 0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk) addr <= a;
      rd <= 1;
      @(posedge clk) rd <= 0;
      #1 check(nm, rdata, exp);
   endtask
   task automatic store(input logic [31:0] tgt, input logic [31:0] v);
      wreg(`A_TARGET, tgt);
      wreg(`A_PENDING, v);
      wreg(`A_STORE, 32'h0000_0000);
   endtask
   task automatic sec(input int k);
      repeat (k) begin
         @(posedge clk) tick <= 1;
         @(posedge clk) tick <= 0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic hold(input int k);
      n = 0;
      @(posedge clk) press <= 5'h01;
      repeat (k) @(posedge clk) n += menu[0];
      press <= 5'h00;
      repeat (20) @(posedge clk) n += menu[0];
   endtask
   task automatic wrap_up;
      $display("checked %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #1ms num_errors++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1;
      rreg(`A_SERIAL, 32'h0000_0001, "serial");
      @(posedge clk) fv <= 1;
      @(posedge clk) fv <= 0;
      #1 check("answer0", ans, 0);
      store({25'h0, 7'h08}, 32'h0000_0005);
      @(posedge clk) fv <= 1;
      faddr <= 8'h05;
      @(posedge clk) fv <= 0;
      #1 check("answer", ans, 1);
      hold(4);
      check("short press", n, 0);
      hold(12);
      check("long press", n, 1);
      seed = lfsr(seed);
      @(posedge clk) cnt[0] <= `DEF_ON + 16'h0001 + seed[8:0];
      sec(1);
      check("relay on", relay[0], 1);
      check("analog", ana[0], scale(cnt[0], `DEF_GAIN));
      seed = lfsr(seed);
      @(posedge clk) cnt[0] <= {7'h00, seed[8:0]};
      sec(2);
      check("relay held", relay[0], 1);
      sec(1);
      check("relay off", relay[0], 0);
      for (int t = 68; t < 72; t++) begin
         @(posedge clk) temp1 <= 8'(t);
         sec(1);
         check("hot alarm", alarm, {2'b00, hot(8'(t))});
      end
      wreg(`A_LOCK, 32'h0000_5A5A);
      store({25'h0, 7'h03}, 32'h0000_0005);
      rreg(`A_READBACK, 32'h0000_0001, "locked");
      wreg(`A_LOCK, 32'h0000_5A5A);
      wreg(`A_PENDING, 32'h0000_0007);
      rreg(`A_READBACK, 32'h0000_0001, "pending");
      wreg(`A_STORE, 32'h0000_0000);
      rreg(`A_READBACK, 32'h0000_0007, "stored");
      check("temp", tshow, 32'h0000_0047);
      @(posedge clk) alt <= 3'h2;
      wreg(`A_ALTSEL, 32'h0000_0001);
      @(posedge clk);
      #1 check("active", act, 32'h0000_0003);
      store({25'h0, 7'h0D}, 32'h0000_0001);
      wreg(`A_STORE, 32'h0000_0000);
      #1 check("default", ser, 32'h0000_0001);
      @(posedge clk);
      #1 check("primary", act, 32'h0000_0002);
      store({25'h0, 7'h0E}, 32'h0000_0001);
      #1 check("armed only", poff, 0);
      wreg(`A_STORE, 32'h0000_0000);
      #1 check("power off", poff, 1);
      repeat (5) @(posedge clk);
      #1 check("restart", {poff, prst}, 32'h0000_0001);
      store({25'h0, 7'h01}, 32'h0000_0002);
      rreg(`A_READBACK, 32'h0000_0002, "mode");
      store({25'h0, 7'h50}, 32'h0000_0001);
      rreg(`A_READBACK, 32'h0000_0002, "in use");
      wreg(`A_TARGET, 32'h0000_0004);
      wreg(`A_PENDING, 32'h0000_0064);
      @(posedge clk);
      #1 check("gain live", ana[0], scale(cnt[0], 7'h64));
      wreg(`A_TARGET, 32'h0000_0013);
      @(posedge clk);
      #1 check("no sensor", tshow, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
